// ---- iss_pkg.sv ----
// constants shared by the signal scaling block
package iss_pkg;
   // ==================== timing ====================
   localparam int CLK_HZ = 40_000_000;
   localparam int GATE_TIME_MS = 1000; // pulse counting window
   localparam int FILT_STEP_MS = 10; // filter update interval, one hundredth of a second
   localparam int GATE_CYCLES = CLK_HZ / 1000 * GATE_TIME_MS;
   localparam int FILT_STEP_CYCLES = CLK_HZ / 1000 * FILT_STEP_MS;
   // ==================== pulse rate input ====================
   localparam logic [11:0] RATE_MAX = 12'hbb8; // 3000 Hz
   localparam logic [11:0] LOW_LIMIT_RST = 12'h064; // 100 Hz
   localparam logic [11:0] HIGH_LIMIT_RST = 12'h3e8; // 1000 Hz
   localparam logic [13:0] GAIN_UNITY = 14'h03e8; // 1.000
   localparam logic [13:0] GAIN_MAX = 14'h270f; // 9.999
   localparam logic signed [47:0] PCT_FULL_T = 48'sh3e8; // 100.0 % in tenths
   localparam logic signed [47:0] Q15_FULL = 48'sh7fff; // 15-bit full scale
   localparam logic [2:0] SEL_OFF = 3'h0;
   localparam logic [2:0] SEL_MAX = 3'h4;
   localparam logic [10:0] FILT_CONST_MAX = 11'h640; // 16.00 s
   // ==================== analog output sources ====================
   localparam logic [4:0] SRC_SPEED_REF = 5'h00;
   localparam logic [4:0] SRC_SPEED_ACT = 5'h02;
   localparam logic [4:0] SRC_CURR_TOTAL = 5'h05;
   localparam logic [4:0] SRC_CURR_ACTIVE = 5'h07;
   localparam logic [4:0] SRC_TORQUE = 5'h0b;
   localparam logic [4:0] SRC_LOGIC_WORD = 5'h0c;
   localparam logic [4:0] SRC_OVERLOAD = 5'h10;
   localparam logic [4:0] SRC_MON_ONE = 5'h12;
   localparam logic [4:0] SRC_MON_TWO = 5'h13;
   localparam logic [4:0] SRC_APP_FIRST = 5'h15;
   localparam logic [4:0] SRC_APP_LAST = 5'h1c;
   localparam logic [16:0] SCALE_WORD = 17'h07fff; // 32767
   localparam logic [16:0] SCALE_TORQUE = 17'h007d0; // 200.0 % in tenths
   localparam logic [16:0] SCALE_OVERLOAD = 17'h003e8; // 100.0 % in tenths
   localparam logic [16:0] SCALE_NONE = 17'h00001;
   // ==================== analog output signal types ====================
   localparam logic [2:0] SIG_V10 = 3'h0;
   localparam logic [2:0] SIG_MA20 = 3'h1;
   localparam logic [2:0] SIG_MA4_20 = 3'h2;
   localparam logic [2:0] SIG_V10_REV = 3'h3;
   localparam logic [2:0] SIG_MA20_REV = 3'h4;
   localparam logic [2:0] SIG_MA4_20_REV = 3'h5;
   localparam logic [15:0] SPAN_10V = 16'h2710; // 10000 mV
   localparam logic [15:0] SPAN_20MA = 16'h4e20; // 20000 uA
   localparam logic [15:0] SPAN_16MA = 16'h3e80; // 16000 uA
   localparam logic [15:0] BASE_4MA = 16'h0fa0; // 4000 uA
   localparam logic [47:0] GAIN_DIV = 48'h3e8; // gain is in thousandths
endpackage

// ---- iss_ao_if.sv ----
// one analog output channel: selected source, scale, gain, type and code
`timescale 1ns/1ps
`default_nettype none
interface iss_ao_if;
   logic [15:0] srcVal;
   logic [16:0] scale;
   logic [13:0] gain;
   logic [2:0] sigType;
   logic [15:0] code;
   modport feed (output srcVal, output scale, output gain, output sigType, input code);
   modport chan (input srcVal, input scale, input gain, input sigType, output code);
endinterface
`default_nettype wire

// ---- iss_ao_channel.sv ----
// analog output channel: ratio times gain mapped onto the selected range
`timescale 1ns/1ps
`default_nettype none
module iss_ao_channel
   import iss_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // channel carrier
   iss_ao_if.chan ao
);
   // ==================== scaling ====================
   // span and base of the selected range
   wire logic [2:0] typeEff = (ao.sigType > SIG_MA4_20_REV) ? SIG_V10 : ao.sigType;
   wire logic isReverse = (typeEff >= SIG_V10_REV);
   wire logic [15:0] span = (typeEff == SIG_V10 || typeEff == SIG_V10_REV) ? SPAN_10V :
      (typeEff == SIG_MA20 || typeEff == SIG_MA20_REV) ? SPAN_20MA : SPAN_16MA;
   wire logic [15:0] base = (typeEff == SIG_MA4_20) ? BASE_4MA : 16'h0000;
   wire logic [15:0] top = (typeEff == SIG_V10_REV) ? SPAN_10V : SPAN_20MA;
   // source over scale times gain times span
   wire logic [47:0] num = {32'h0, ao.srcVal} * {34'h0, ao.gain} * {32'h0, span};
   wire logic [47:0] den = {31'h0, ao.scale} * GAIN_DIV;
   wire logic [47:0] quo = (den == 48'h0) ? 48'h0 : num / den;
   wire logic [15:0] part = (quo > {32'h0, span}) ? span : quo[15:0];
   wire logic [15:0] codeNxt = isReverse ? (top - part) : (base + part);

   // registered output code
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ao.code <= 16'h0000;
      end else begin
         ao.code <= codeNxt;
      end
   end

   // ==================== checks ====================
   property p_code_in_range;
      @(posedge clk) disable iff (!rst_n)
      ao.code <= SPAN_20MA;
   endproperty
   a_code_in_range: assert property (p_code_in_range) else $error("output code beyond range");

   property p_reverse_zero;
      @(posedge clk) disable iff (!rst_n)
      (ao.sigType == SIG_V10_REV && ao.srcVal == 16'h0000) |=> (ao.code == SPAN_10V);
   endproperty
   a_reverse_zero: assert property (p_reverse_zero) else $error("reversed volt not at top");

   property p_unity_full;
      @(posedge clk) disable iff (!rst_n)
      (ao.sigType == SIG_MA4_20 && ao.gain == GAIN_UNITY && {1'b0, ao.srcVal} == ao.scale && ao.scale != 17'h0)
         |=> (ao.code == SPAN_20MA);
   endproperty
   a_unity_full: assert property (p_unity_full) else $error("full scale not at 20 mA");
endmodule
`default_nettype wire

// ---- iss_pulse_meter.sv ----
// counts rising edges over a fixed window and reports whole hertz
`timescale 1ns/1ps
`default_nettype none
module iss_pulse_meter
   import iss_pkg::*;
#(
   parameter int GATE_LEN = GATE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pulse level, already synchronised, and enable
   input wire logic pulseLevel,
   input wire logic enable,
   // measured rate
   output logic [11:0] rateHz
);
   logic [31:0] gateCnt_r;
   logic [11:0] edgeCnt_r;
   logic prevLevel_r;

   // ==================== counting ====================
   wire logic risingEdge = pulseLevel && !prevLevel_r;
   wire logic gateEnd = (gateCnt_r == 32'(GATE_LEN - 1));
   wire logic [11:0] edgeSat = (edgeCnt_r > RATE_MAX) ? RATE_MAX : edgeCnt_r;

   // window counter and edge counter
   always_ff @(posedge clk) begin
      if (!rst_n || !enable) begin
         gateCnt_r <= 32'h0;
         edgeCnt_r <= 12'h000;
         prevLevel_r <= 1'b0;
      end else begin
         prevLevel_r <= pulseLevel;
         gateCnt_r <= gateEnd ? 32'h0 : gateCnt_r + 32'h1;
         if (gateEnd) begin
            edgeCnt_r <= {11'h000, risingEdge};
         end else if (risingEdge && edgeCnt_r != 12'hfff) begin
            edgeCnt_r <= edgeCnt_r + 12'h001;
         end
      end
   end

   // readout held at zero while disabled
   always_ff @(posedge clk) begin
      if (!rst_n || !enable) begin
         rateHz <= 12'h000;
      end else if (gateEnd) begin
         rateHz <= edgeSat;
      end
   end

   // ==================== checks ====================
   property p_rate_band;
      @(posedge clk) disable iff (!rst_n)
      rateHz <= RATE_MAX;
   endproperty
   a_rate_band: assert property (p_rate_band) else $error("rate above band");

   property p_off_zero;
      @(posedge clk) disable iff (!rst_n)
      !enable |=> (rateHz == 12'h000);
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("rate not cleared when off");
endmodule
`default_nettype wire

// ---- iss_signal_scaling.sv ----
// drive i/o conditioning: input levels, pulse rate input and two analog outputs
`timescale 1ns/1ps
`default_nettype none
module iss_signal_scaling
   import iss_pkg::*;
#(
   parameter int GATE_LEN = GATE_CYCLES,
   parameter int FILT_STEP = FILT_STEP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // digital input pins and polarity (0 sinking, 1 sourcing)
   input wire logic [7:0] digitalInputPin,
   input wire logic inputPolaritySelect,
   // pulse rate input settings
   input wire logic [2:0] pulseInputSelect,
   input wire logic [13:0] pulseGain,
   input wire logic [11:0] pulseLowLimit,
   input wire logic [11:0] pulseHighLimit,
   input wire logic signed [10:0] pulseOffset,
   input wire logic [10:0] sharedFilterConstant,
   // analog output settings
   input wire logic [4:0] outOneSource,
   input wire logic [13:0] outOneGain,
   input wire logic [2:0] outOneSignalType,
   input wire logic [4:0] outTwoSource,
   input wire logic [13:0] outTwoGain,
   input wire logic [2:0] outTwoSignalType,
   // internal quantities and their settings
   input wire logic [15:0] speedReference,
   input wire logic [15:0] actualSpeed,
   input wire logic [15:0] totalCurrent,
   input wire logic [15:0] activeCurrent,
   input wire logic [15:0] motorTorque,
   input wire logic [15:0] motorOverload,
   input wire logic [15:0] logicWord,
   input wire logic [7:0][15:0] appWord,
   input wire logic [15:0] maxSpeedSetting,
   input wire logic [15:0] ratedCurrentSetting,
   // monitor word writes from communication
   input wire logic monWrite,
   input wire logic monSelect,
   input wire logic [15:0] monData,
   // status outputs
   output logic [7:0] inputLevelWord,
   output logic [11:0] pulseRateReadout,
   output logic signed [15:0] pulseScaled,
   output logic pulseReverse,
   output logic [15:0] pulseMagnitude,
   output logic [15:0] monitorWordOne,
   output logic [15:0] monitorWordTwo,
   // analog output codes (mV for voltage types, uA for current types)
   output logic [15:0] outOneCode,
   output logic [15:0] outTwoCode
);
   // ==================== input synchroniser ====================
   logic [7:0] pinMeta_r;
   logic [7:0] pinSync_r;

   // two flip-flops before any logic
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinMeta_r <= 8'h00;
         pinSync_r <= 8'h00;
      end else begin
         pinMeta_r <= digitalInputPin;
         pinSync_r <= pinMeta_r;
      end
   end

   // ==================== input level word ====================
   wire logic selValid = (pulseInputSelect != SEL_OFF) && (pulseInputSelect <= SEL_MAX);
   wire logic [7:0] activeLevels = inputPolaritySelect ? pinSync_r : ~pinSync_r;
   wire logic [7:0] pulseMask = selValid ? (8'h01 << (pulseInputSelect - 3'h1)) : 8'h00;
   wire logic [7:0] levelNxt = activeLevels & ~pulseMask;
   wire logic pulsePin = |(pinSync_r & pulseMask);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         inputLevelWord <= 8'h00;
      end else begin
         inputLevelWord <= levelNxt;
      end
   end

   // ==================== pulse rate measurement ====================
   logic [11:0] rateHz;

   iss_pulse_meter #(
      .GATE_LEN(GATE_LEN)
   ) uMeter (
      .clk(clk),
      .rst_n(rst_n),
      .pulseLevel(pulsePin),
      .enable(selValid),
      .rateHz(rateHz)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulseRateReadout <= 12'h000;
      end else begin
         pulseRateReadout <= selValid ? rateHz : 12'h000;
      end
   end

   // ==================== pulse scaling ====================
   // settings clipped to their adjustable ranges
   wire logic [11:0] lowLim = (pulseLowLimit == 12'h000) ? 12'h001 :
      (pulseLowLimit > RATE_MAX) ? RATE_MAX : pulseLowLimit;
   wire logic [11:0] highLim = (pulseHighLimit == 12'h000) ? 12'h001 :
      (pulseHighLimit > RATE_MAX) ? RATE_MAX : pulseHighLimit;
   wire logic [13:0] gainLim = (pulseGain > GAIN_MAX) ? GAIN_MAX : pulseGain;
   wire logic signed [10:0] offLim = (pulseOffset > 11'sd1000) ? 11'sd1000 :
      (pulseOffset < -11'sd1000) ? -11'sd1000 : pulseOffset;
   // ((rate - low) / (high - low) * 100 % + offset) * gain, in tenths of a percent
   wire logic signed [47:0] spanS = $signed({36'h0, highLim}) - $signed({36'h0, lowLim});
   wire logic signed [47:0] diffS = $signed({36'h0, pulseRateReadout}) - $signed({36'h0, lowLim});
   wire logic signed [47:0] ratioT = (spanS > 48'sh0) ? (diffS * PCT_FULL_T) / spanS : 48'sh0;
   wire logic signed [47:0] sumT = ratioT + {{37{offLim[10]}}, offLim};
   wire logic signed [47:0] gainT = (sumT * $signed({34'h0, gainLim})) / $signed(GAIN_DIV);
   wire logic signed [47:0] clipT = (gainT > PCT_FULL_T) ? PCT_FULL_T :
      (gainT < -PCT_FULL_T) ? -PCT_FULL_T : gainT;
   wire logic signed [47:0] q15 = (clipT * Q15_FULL) / PCT_FULL_T;
   logic signed [15:0] target_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         target_r <= 16'sh0000;
      end else begin
         target_r <= q15[15:0];
      end
   end

   // ==================== first-order filter ====================
   logic [31:0] stepCnt_r;
   logic signed [39:0] filtAcc_r;
   wire logic stepTick = (stepCnt_r == 32'(FILT_STEP - 1));
   wire logic [10:0] constLim = (sharedFilterConstant > FILT_CONST_MAX) ? FILT_CONST_MAX :
      sharedFilterConstant;
   wire logic bypass = (constLim == 11'h000);
   wire logic signed [39:0] targetWide = $signed({{8{target_r[15]}}, target_r, 16'h0000});
   // one step of y += (x - y) / (tau / step)
   wire logic signed [39:0] filtStep = (targetWide - filtAcc_r) / $signed({29'h0, constLim});
   wire logic signed [39:0] filtNxt = bypass ? targetWide : filtAcc_r + filtStep;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stepCnt_r <= 32'h0;
         filtAcc_r <= 40'sh0;
      end else begin
         stepCnt_r <= stepTick ? 32'h0 : stepCnt_r + 32'h1;
         if (stepTick || bypass) begin
            filtAcc_r <= filtNxt;
         end
      end
   end

   // ==================== pulse outputs ====================
   wire logic signed [15:0] filtOut = filtAcc_r[31:16];
   wire logic [15:0] filtMag = filtOut[15] ? (16'h0000 - filtOut) : filtOut;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulseScaled <= 16'sh0000;
         pulseReverse <= 1'b0;
         pulseMagnitude <= 16'h0000;
      end else begin
         pulseScaled <= filtOut;
         pulseReverse <= filtOut[15];
         pulseMagnitude <= filtMag;
      end
   end

   // ==================== monitor words ====================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         monitorWordOne <= 16'h0000;
         monitorWordTwo <= 16'h0000;
      end else if (monWrite) begin
         if (!monSelect) begin
            monitorWordOne <= monData;
         end else begin
            monitorWordTwo <= monData;
         end
      end
   end

   // ==================== analog outputs ====================
   iss_ao_if aoBus[2] ();
   wire logic [4:0] srcSel[2];
   wire logic [13:0] gainSel[2];
   wire logic [2:0] typeSel[2];
   wire logic [16:0] twiceRated = {ratedCurrentSetting, 1'b0};
   assign srcSel[0] = outOneSource;
   assign srcSel[1] = outTwoSource;
   assign gainSel[0] = outOneGain;
   assign gainSel[1] = outTwoGain;
   assign typeSel[0] = outOneSignalType;
   assign typeSel[1] = outTwoSignalType;

   // source and full scale selection per channel
   for (genvar g = 0; g < 2; g++) begin : gChan
      wire logic isApp = (srcSel[g] >= SRC_APP_FIRST) && (srcSel[g] <= SRC_APP_LAST);
      wire logic [2:0] appIdx = 3'(srcSel[g] - SRC_APP_FIRST);
      assign aoBus[g].srcVal =
         (srcSel[g] == SRC_SPEED_REF) ? speedReference :
         (srcSel[g] == SRC_SPEED_ACT) ? actualSpeed :
         (srcSel[g] == SRC_CURR_TOTAL) ? totalCurrent :
         (srcSel[g] == SRC_CURR_ACTIVE) ? activeCurrent :
         (srcSel[g] == SRC_TORQUE) ? motorTorque :
         (srcSel[g] == SRC_LOGIC_WORD) ? logicWord :
         (srcSel[g] == SRC_OVERLOAD) ? motorOverload :
         (srcSel[g] == SRC_MON_ONE) ? monitorWordOne :
         (srcSel[g] == SRC_MON_TWO) ? monitorWordTwo :
         isApp ? appWord[appIdx] : 16'h0000;
      assign aoBus[g].scale =
         (srcSel[g] == SRC_SPEED_REF || srcSel[g] == SRC_SPEED_ACT) ? {1'b0, maxSpeedSetting} :
         (srcSel[g] == SRC_CURR_TOTAL || srcSel[g] == SRC_CURR_ACTIVE) ? twiceRated :
         (srcSel[g] == SRC_TORQUE) ? SCALE_TORQUE :
         (srcSel[g] == SRC_OVERLOAD) ? SCALE_OVERLOAD :
         (srcSel[g] == SRC_LOGIC_WORD || srcSel[g] == SRC_MON_ONE || srcSel[g] == SRC_MON_TWO
            || isApp) ? SCALE_WORD : SCALE_NONE;
      assign aoBus[g].gain = (gainSel[g] > GAIN_MAX) ? GAIN_MAX : gainSel[g];
      assign aoBus[g].sigType = typeSel[g];

      iss_ao_channel uChan (
         .clk(clk),
         .rst_n(rst_n),
         .ao(aoBus[g])
      );
   end

   // output codes re-registered at the top boundary
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outOneCode <= 16'h0000;
         outTwoCode <= 16'h0000;
      end else begin
         outOneCode <= aoBus[0].code;
         outTwoCode <= aoBus[1].code;
      end
   end

   // ==================== checks ====================
   property p_sel_off_zero;
      @(posedge clk) disable iff (!rst_n)
      (pulseInputSelect == SEL_OFF)[*3] |-> (pulseRateReadout == 12'h000);
   endproperty
   a_sel_off_zero: assert property (p_sel_off_zero) else $error("rate readout not zero");

   property p_di3_masked;
      @(posedge clk) disable iff (!rst_n)
      (pulseInputSelect == 3'h3) |=> !inputLevelWord[2];
   endproperty
   a_di3_masked: assert property (p_di3_masked) else $error("pulse input bit not zero");

   property p_level_polarity;
      @(posedge clk) disable iff (!rst_n)
      (pulseInputSelect == SEL_OFF && inputPolaritySelect) |=> (inputLevelWord == $past(pinSync_r));
   endproperty
   a_level_polarity: assert property (p_level_polarity) else $error("sourcing level wrong");

   property p_readout_band;
      @(posedge clk) disable iff (!rst_n)
      pulseRateReadout <= RATE_MAX;
   endproperty
   a_readout_band: assert property (p_readout_band) else $error("readout above band");

   property p_bypass;
      @(posedge clk) disable iff (!rst_n)
      (sharedFilterConstant == 11'h000) |=> (filtAcc_r[31:16] == $past(target_r));
   endproperty
   a_bypass: assert property (p_bypass) else $error("filter not bypassed");

   property p_reverse_sign;
      @(posedge clk) disable iff (!rst_n)
      pulseReverse == pulseScaled[15];
   endproperty
   a_reverse_sign: assert property (p_reverse_sign) else $error("direction flag wrong");

   property p_mon_write;
      @(posedge clk) disable iff (!rst_n)
      (monWrite && !monSelect) |=> (monitorWordOne == $past(monData));
   endproperty
   a_mon_write: assert property (p_mon_write) else $error("monitor word not written");

   property p_torque_scale;
      @(posedge clk) disable iff (!rst_n)
      (outOneSource == SRC_TORQUE) |-> (aoBus[0].scale == SCALE_TORQUE);
   endproperty
   a_torque_scale: assert property (p_torque_scale) else $error("torque scale wrong");

   property p_current_scale;
      @(posedge clk) disable iff (!rst_n)
      (outTwoSource == SRC_CURR_TOTAL) |-> (aoBus[1].scale == {ratedCurrentSetting, 1'b0});
   endproperty
   a_current_scale: assert property (p_current_scale) else $error("current scale wrong");
endmodule
`default_nettype wire

// ---- iss_field_model.sv ----
// field pulse source feeding one digital input pin
`timescale 1ns/1ps
`default_nettype none
module iss_field_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // half period in cycles, 0 stops the source
   input wire logic [7:0] halfPeriod,
   // pulse pin level
   output logic pulse
);
   logic [7:0] cnt_r;
   // square wave, held low while stopped
   always_ff @(posedge clk) begin
      if (!rst_n || halfPeriod == 8'h00) begin
         cnt_r <= 8'h00;
         pulse <= 1'b0;
      end else if (cnt_r == halfPeriod - 8'h01) begin
         cnt_r <= 8'h00;
         pulse <= !pulse;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ---- test_iss_signal_scaling.sv ----
// self-checking bench for the signal scaling block
`timescale 1ns/1ps
`default_nettype none
module test_iss_signal_scaling;
   import iss_pkg::*;
   // ==========
   // stimulus and observed signals
   logic clk = 1'b0, rst_n = 1'b0, inputPolaritySelect = 1'b1, monWrite = 1'b0, monSelect = 1'b0;
   logic fp, pulseReverse;
   logic [7:0] pinsR = 8'h00, half = 8'h00, inputLevelWord;
   logic [2:0] pulseInputSelect = 3'h0, outOneSignalType = 3'h0, outTwoSignalType = 3'h0;
   logic [13:0] pulseGain = GAIN_UNITY, outOneGain = GAIN_UNITY, outTwoGain = GAIN_UNITY;
   logic [11:0] pulseLowLimit = LOW_LIMIT_RST, pulseHighLimit = HIGH_LIMIT_RST, pulseRateReadout;
   logic signed [10:0] pulseOffset = 11'sh000;
   logic [10:0] sharedFilterConstant = 11'h000;
   logic [4:0] outOneSource = 5'h00, outTwoSource = 5'h00;
   logic [15:0] speedReference = 16'h02ee, maxSpeedSetting = 16'h05dc, actualSpeed = 16'h05dc;
   logic [15:0] totalCurrent = 16'h01f4, ratedCurrentSetting = 16'h01f4, activeCurrent = 16'h03e8;
   logic [15:0] motorTorque = 16'h01f4, motorOverload = 16'h00fa, logicWord = 16'h3fff, monData = 16'h0000;
   logic [15:0] pulseMagnitude, monitorWordOne, monitorWordTwo, outOneCode, outTwoCode;
   logic signed [15:0] pulseScaled;
   logic [7:0][15:0] appWord = {16'h7fff, {7{16'h3fff}}};
   wire logic [7:0] digitalInputPin = pinsR | {5'h00, fp, 2'h0};
   int n_mismatch = 0, checks_done = 0;
   // clock, 25 ns period
   always #12.5 clk = !clk;
   iss_field_model field (.clk, .rst_n, .halfPeriod(half), .pulse(fp));
   iss_signal_scaling #(.GATE_LEN(1000), .FILT_STEP(20)) uut (.clk, .rst_n, .digitalInputPin,
      .inputPolaritySelect, .pulseInputSelect, .pulseGain, .pulseLowLimit, .pulseHighLimit, .pulseOffset,
      .sharedFilterConstant, .outOneSource, .outOneGain, .outOneSignalType, .outTwoSource, .outTwoGain,
      .outTwoSignalType, .speedReference, .actualSpeed, .totalCurrent, .activeCurrent, .motorTorque,
      .motorOverload, .logicWord, .appWord, .maxSpeedSetting, .ratedCurrentSetting, .monWrite, .monSelect,
      .monData, .inputLevelWord, .pulseRateReadout, .pulseScaled, .pulseReverse, .pulseMagnitude,
      .monitorWordOne, .monitorWordTwo, .outOneCode, .outTwoCode);
   // ==========
   // tasks
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // both channels get the same setting and must agree
   task automatic ao(input logic [4:0] s, input logic [13:0] g, input logic [2:0] t, input logic [15:0] e);
      @(posedge clk);
      outOneSource <= s;
      outTwoSource <= s;
      outOneGain <= g;
      outTwoGain <= g;
      outOneSignalType <= t;
      outTwoSignalType <= t;
      repeat (4) @(posedge clk);
      #1;
      chk("code one", e, outOneCode);
      chk("code two", e, outTwoCode);
   endtask
   // one-cycle write strobe
   task automatic mon(input logic s, input logic [15:0] d);
      @(posedge clk);
      monWrite <= 1'b1;
      monSelect <= s;
      monData <= d;
      @(posedge clk);
      monWrite <= 1'b0;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ==========
   // test sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("reset levels", 16'h0000, {8'h00, inputLevelWord});
      chk("reset rate", 16'h0000, {4'h0, pulseRateReadout});
      $display("end reset");
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         inputPolaritySelect <= p[0];
         pinsR <= 8'h5a;
         repeat (5) @(posedge clk);
         #1;
         chk("levels", {8'h00, p[0] ? 8'h5a : 8'ha5}, {8'h00, inputLevelWord});
      end
      @(posedge clk);
      pinsR <= 8'h00;
      $display("end levels");
      ao(5'h00, 14'h3e8, 3'h0, 16'h1388);
      ao(5'h05, 14'h3e8, 3'h0, 16'h1388);
      ao(5'h02, 14'h3e8, 3'h2, 16'h4e20);
      ao(5'h07, 14'h3e8, 3'h4, 16'h0000);
      ao(5'h01, 14'h3e8, 3'h3, 16'h2710);
      ao(5'h0b, 14'h3e8, 3'h0, 16'h09c4);
      ao(5'h10, 14'h3e8, 3'h0, 16'h09c4);
      ao(5'h0c, 14'h3e8, 3'h0, 16'h1387);
      ao(5'h1c, 14'h3e8, 3'h0, 16'h2710);
      ao(5'h0c, 14'h3e8, 3'h1, 16'h270f);
      ao(5'h0c, 14'h3e8, 3'h2, 16'h2edf);
      ao(5'h0c, 14'h3e8, 3'h3, 16'h1389);
      ao(5'h0c, 14'h3e8, 3'h4, 16'h2711);
      ao(5'h0c, 14'h3e8, 3'h5, 16'h2ee1);
      ao(5'h0c, 14'h000, 3'h0, 16'h0000);
      ao(5'h0c, 14'h270f, 3'h0, 16'h2710);
      ao(5'h0c, 14'h270f, 3'h5, 16'h0fa0);
      $display("end analog");
      mon(1'b0, 16'hffff);
      mon(1'b1, 16'h1234);
      #1;
      chk("word one", 16'hffff, monitorWordOne);
      chk("word two", 16'h1234, monitorWordTwo);
      ao(5'h12, 14'h3e8, 3'h0, 16'h2710);
      ao(5'h13, 14'h3e8, 3'h3, 16'h2182);
      $display("end monitor");
      @(posedge clk);
      half <= 8'h02;
      pulseInputSelect <= 3'h3;
      pulseHighLimit <= 12'h190;
      pulseOffset <= -11'sh3e8;
      pulseGain <= 14'h7d0;
      repeat (3200) @(posedge clk);
      #1;
      chk("rate", 16'h00fa, {4'h0, pulseRateReadout});
      chk("levels", 16'h0000, {8'h00, inputLevelWord});
      chk("scaled", 16'h8001, pulseScaled);
      chk("reverse", 16'h0001, {15'h0, pulseReverse});
      chk("magnitude", 16'h7fff, pulseMagnitude);
      @(posedge clk);
      pulseOffset <= 11'sh1f4;
      pulseGain <= GAIN_UNITY;
      repeat (50) @(posedge clk);
      #1;
      chk("scaled", 16'h7fff, pulseScaled);
      chk("reverse", 16'h0000, {15'h0, pulseReverse});
      // slowest constant: exactly one step lands in 22 cycles
      @(posedge clk);
      sharedFilterConstant <= 11'h640;
      pulseGain <= 14'h000;
      repeat (22) @(posedge clk);
      #1;
      chk("filter step", 16'h7fea, pulseScaled);
      @(posedge clk);
      sharedFilterConstant <= 11'h002;
      repeat (1000) @(posedge clk);
      #1;
      chk("filter settled", 16'h0000, pulseMagnitude);
      @(posedge clk);
      pulseInputSelect <= 3'h0;
      repeat (2100) @(posedge clk);
      #1;
      chk("rate off", 16'h0000, {4'h0, pulseRateReadout});
      $display("end pulse");
      conclude();
   end
endmodule
`default_nettype wire
